/* File: testbench.sv */
`timescale 1ns/1ns
`include "tmr_map.svh"
module testbench;
  logic        clk_i, rst_i, cyc, stb, we, xrun, xtal, xout, pin, irq, ack, p;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [1:0]  svc;
  logic [31:0] dat, rdat, q, v, e, m;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  int          err_count, checks_done, seed, cyc_n, n;

  tmr_core u_tmr_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_svc_i(svc), .crystal_pin_in(xtal), .crystal_pin_out(xout),
    .compare_output_pin(pin), .irq_o(irq));
  tmr_xtal_model u_tmr_xtal_model (.run_i(xrun), .osc_o(xtal));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
    eq.push_back(x);
    mq.push_back(k);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask : rd

  // Read results are matched against the oldest note
  always @(posedge clk_i)
    if (ack === 1'b1 && we === 1'b0 && eq.size() > 0)
    begin
      e = eq.pop_front();
      m = mq.pop_front();
      check("read data", rdat & m, e & m);
    end

  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      err_count++;
      stop_test();
    end
  end

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    seed = 59755;
    rst_i = 1'b1;
    {cyc, stb, we, adr, sel, dat, svc, xrun} = 50'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 7; i++)
      rd(8'(i * 4), 32'h0, 32'hFFFFFFFF);
    v = {24'h0, 8'($random(seed))};
    wr(`TMR_OFS_COUNT, v);
    bus(1'b1, `TMR_OFS_COUNT, ~v, 4'hE);
    repeat (20) @(posedge clk_i);
    rd(`TMR_OFS_COUNT, v, 32'hFF);
    v = {24'h0, 8'($random(seed))};
    wr(`TMR_OFS_COMPARE, v);
    rd(`TMR_OFS_COMPARE, v, 32'hFF);
    wr(`TMR_OFS_COMPARE, 32'h80);
    wr(`TMR_OFS_COUNT, 32'hFE);
    wr(`TMR_OFS_CTRL, 32'h01);
    repeat (6) @(posedge clk_i);
    wr(`TMR_OFS_CTRL, 32'h00);
    rd(`TMR_OFS_FLAGS, 32'h01, 32'h03);
    check("irq masked", 32'(irq), 32'h0);
    wr(`TMR_OFS_MASKS, 32'h01);
    @(posedge clk_i);
    check("irq unmasked", 32'(irq), 32'h1);
    svc <= 2'h1;
    @(posedge clk_i);
    svc <= 2'h0;
    rd(`TMR_OFS_FLAGS, 32'h0, 32'h03);
    check("irq serviced", 32'(irq), 32'h0);
    v = 32'h20 + (32'($random(seed)) & 32'h7F);
    wr(`TMR_OFS_FLAGS, 32'h03);
    wr(`TMR_OFS_MASKS, 32'h02);
    wr(`TMR_OFS_COMPARE, v);
    wr(`TMR_OFS_COUNT, v - 32'h10);
    wr(`TMR_OFS_CTRL, 32'h01);
    n = 0;
    while (irq !== 1'b1 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    check("match delay", 32'(n >= 12 && n <= 22), 32'h1);
    wr(`TMR_OFS_CTRL, 32'h00);
    rd(`TMR_OFS_FLAGS, 32'h02, 32'h03);
    wr(`TMR_OFS_FLAGS, 32'h02);
    rd(`TMR_OFS_FLAGS, 32'h0, 32'h03);
    check("irq cleared", 32'(irq), 32'h0);
    wr(`TMR_OFS_COMPARE, 32'h05);
    wr(`TMR_OFS_COUNT, 32'h00);
    wr(`TMR_OFS_CTRL, 32'h31);
    n = 0;
    p = pin;
    repeat (60)
    begin
      @(posedge clk_i);
      n = n + int'(pin !== p);
      p = pin;
    end
    check("toggles", 32'(n >= 8 && n <= 12), 32'h1);
    wr(`TMR_OFS_CTRL, 32'h11);
    repeat (4) @(posedge clk_i);
    check("pin off", 32'(pin), 32'h0);
    wr(`TMR_OFS_CTRL, 32'h00);
    rd(`TMR_OFS_COUNT, 32'h0, 32'hF8);
    rd(`TMR_OFS_FLAGS, 32'h0, 32'h01);
    // Fast then phase-correct PWM, high time over exactly one period
    wr(`TMR_OFS_COMPARE, 32'h40);
    wr(`TMR_OFS_COUNT, 32'h00);
    for (int k = 0; k < 2; k++)
    begin
      wr(`TMR_OFS_CTRL, (k == 1) ? 32'h49 : 32'h59);
      repeat (520) @(posedge clk_i);
      n = 0;
      repeat ((k == 1) ? 510 : 256)
      begin
        @(posedge clk_i);
        n = n + int'(pin === 1'b1);
      end
      check("pwm duty", 32'(n), (k == 1) ? 32'd128 : 32'd65);
    end
    wr(`TMR_OFS_CTRL, 32'h00);
    wr(`TMR_OFS_COUNT, 32'h00);
    wr(`TMR_OFS_ASYNC, 32'h08);
    rd(`TMR_OFS_ASYNC, 32'h08, 32'h08);
    check("xtal feedback", 32'(xout), 32'h1);
    xrun <= 1'b1;
    wr(`TMR_OFS_CTRL, 32'h01);
    repeat (40) @(posedge clk_i);
    xrun <= 1'b0;
    repeat (10) @(posedge clk_i);
    wr(`TMR_OFS_CTRL, 32'h00);
    rd(`TMR_OFS_COUNT, 32'h0, 32'h0);
    check("crystal ticks", 32'(q[7:0] >= 8'h03 && q[7:0] <= 8'h07), 32'h1);
    stop_test();
  end
endmodule : testbench

/* File: tmr_core.sv */
`timescale 1ns/1ns
`include "tmr_map.svh"
// Contract
// - Count and compare are 8-bit software registers
// - Flags in shared register, each gated by mask
// - Tick from prescaled clock or crystal pins
// - No clock selected: counter holds still
// - Compare buffered value against count every tick
// - Match drives PWM or frequency output pin
// - Match sets compare flag, raises interrupt
// - Zero count means bottom
// - All-ones count means maximum, 255
// - Top is maximum or compare, per mode
// - Default tick source is the I/O clock
// - Async select one takes crystal as source
// - Select zero stops timer, count still accessible
// - CPU count write beats clear or count
// - Compare flag set next tick, overflow flag on its own tick, cleared by service or one

module tmr_core (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [1:0]  irq_svc_i,
  input  wire logic        crystal_pin_in,
  output logic             crystal_pin_out,
  output logic             compare_output_pin,
  output logic             irq_o
);

  logic [7:0]  ctrl_r;
  logic [7:0]  count_value_r;
  logic [7:0]  compare_value_r;
  logic [7:0]  compare_active_r;
  logic [1:0]  timer_irq_flags_r;
  logic [1:0]  timer_irq_masks_r;
  logic        async_clock_select_r;
  logic        dir_r;
  logic        match_pend_r;
  logic        block_r;
  logic        wave_r;
  logic        xin_s1_r;
  logic        xin_s2_r;
  logic        xin_s3_r;

  logic        acc_w;
  logic        wr_w;
  logic        wr_ctrl_w;
  logic        wr_count_w;
  logic        wr_cmp_w;
  logic        wr_flags_w;
  logic        wr_masks_w;
  logic        wr_async_w;
  logic [7:0]  wdat_w;
  logic [31:0] rdat_w;
  logic [2:0]  clock_source_select_w;
  logic [1:0]  mode_w;
  logic [1:0]  com_w;
  logic        pwm_w;
  logic        src_tick_w;
  logic        timer_tick_w;
  logic        at_bottom_w;
  logic        at_max_w;
  logic [7:0]  top_w;
  logic        at_top_w;
  logic [7:0]  count_nxt;
  logic        dir_nxt;
  logic        match_w;
  logic        ovf_evt_w;
  logic        cmp_evt_w;
  logic        force_w;
  logic        wave_nxt;
  logic [1:0]  flags_nxt;

  // Sticky flag: set beats clear
  function automatic logic flag_upd(input logic cur, input logic set, input logic clr);
    return set | (cur & ~clr);
  endfunction : flag_upd

  // Bus decode, write strobes
  assign acc_w      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_w       = acc_w && wb_we_i && wb_sel_i[0];
  assign wdat_w     = wb_dat_i[7:0];
  assign wr_ctrl_w  = wr_w && (wb_adr_i == `TMR_OFS_CTRL);
  assign wr_count_w = wr_w && (wb_adr_i == `TMR_OFS_COUNT);
  assign wr_cmp_w   = wr_w && (wb_adr_i == `TMR_OFS_COMPARE);
  assign wr_flags_w = wr_w && (wb_adr_i == `TMR_OFS_FLAGS);
  assign wr_masks_w = wr_w && (wb_adr_i == `TMR_OFS_MASKS);
  assign wr_async_w = wr_w && (wb_adr_i == `TMR_OFS_ASYNC);

  always_comb
  begin
    rdat_w = 32'h0000_0000;
    case (wb_adr_i)
      `TMR_OFS_CTRL:    rdat_w = {24'h00_0000, 1'b0, ctrl_r[6:0]};
      `TMR_OFS_COUNT:   rdat_w = {24'h00_0000, count_value_r};
      `TMR_OFS_COMPARE: rdat_w = {24'h00_0000, compare_value_r};
      `TMR_OFS_FLAGS:   rdat_w = {30'h0000_0000, timer_irq_flags_r};
      `TMR_OFS_MASKS:   rdat_w = {30'h0000_0000, timer_irq_masks_r};
      `TMR_OFS_ASYNC:   rdat_w = {28'h000_0000, async_clock_select_r, 3'h0};
      default:          rdat_w = 32'h0000_0000;
    endcase
  end

  assign clock_source_select_w = ctrl_r[`TMR_CTRL_CS_LSB +: 3];
  assign mode_w                = ctrl_r[`TMR_CTRL_WM_LSB +: 2];
  assign com_w                 = ctrl_r[`TMR_CTRL_COM_LSB +: 2];
  assign pwm_w = (mode_w == tmr_pkg::TMR_WAVE_PHASE) || (mode_w == tmr_pkg::TMR_WAVE_FAST);

  // Crystal edge detect after two-stage synchroniser
  assign src_tick_w = async_clock_select_r ? (xin_s2_r && !xin_s3_r) : 1'b1;

  tmr_prescale #(
    .PW (10)
  ) u_prescale (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .src_tick_i (src_tick_w),
    .sel_i      (clock_source_select_w),
    .tick_o     (timer_tick_w)
  );

  // Range markers
  assign at_bottom_w = (count_value_r == `TMR_BOTTOM);
  assign at_max_w    = (count_value_r == `TMR_MAX);
  assign top_w       = (mode_w == tmr_pkg::TMR_WAVE_CTC) ? compare_active_r : `TMR_MAX;
  assign at_top_w    = (count_value_r == top_w);
  assign match_w     = (count_value_r == compare_active_r);

  // Counter sequencing per mode
  always_comb
  begin
    count_nxt = count_value_r;
    dir_nxt   = dir_r;
    case (mode_w)
      tmr_pkg::TMR_WAVE_PHASE:
      begin
        if (dir_r == tmr_pkg::TMR_DIR_UP)
        begin
          if (at_top_w)
          begin
            dir_nxt   = tmr_pkg::TMR_DIR_DOWN;
            count_nxt = count_value_r - 8'h01;
          end
          else
            count_nxt = count_value_r + 8'h01;
        end
        else
        begin
          if (at_bottom_w)
          begin
            dir_nxt   = tmr_pkg::TMR_DIR_UP;
            count_nxt = count_value_r + 8'h01;
          end
          else
            count_nxt = count_value_r - 8'h01;
        end
      end
      tmr_pkg::TMR_WAVE_CTC:
      begin
        dir_nxt   = tmr_pkg::TMR_DIR_UP;
        count_nxt = at_top_w ? `TMR_BOTTOM : count_value_r + 8'h01;
      end
      default:
      begin
        dir_nxt   = tmr_pkg::TMR_DIR_UP;
        count_nxt = count_value_r + 8'h01;
      end
    endcase
  end

  // Overflow: at bottom turn in phase mode, else at maximum
  assign ovf_evt_w = timer_tick_w && ((mode_w == tmr_pkg::TMR_WAVE_PHASE)
                     ? (at_bottom_w && dir_r == tmr_pkg::TMR_DIR_DOWN) : at_max_w);
  // Match seen on one tick flags on the next
  assign cmp_evt_w = timer_tick_w && match_pend_r;
  assign force_w   = wr_ctrl_w && wdat_w[`TMR_CTRL_FORCE] && !pwm_w;

  // Waveform generator
  always_comb
  begin
    wave_nxt = wave_r;
    if (force_w || (timer_tick_w && match_w && !block_r && !pwm_w))
    begin
      case (com_w)
        tmr_pkg::TMR_COM_TOGGLE: wave_nxt = ~wave_r;
        tmr_pkg::TMR_COM_CLEAR:  wave_nxt = 1'b0;
        tmr_pkg::TMR_COM_SET:    wave_nxt = 1'b1;
        default:                 wave_nxt = wave_r;
      endcase
    end
    else if (timer_tick_w && pwm_w && com_w[1])
    begin
      case (mode_w)
        tmr_pkg::TMR_WAVE_FAST:
        begin
          if (match_w && !block_r)
            wave_nxt = com_w[0];
          else if (at_max_w)
            wave_nxt = ~com_w[0];
          else
            wave_nxt = wave_r;
        end
        default:
        begin
          if (match_w && !block_r)
            wave_nxt = (dir_r == tmr_pkg::TMR_DIR_UP) ? com_w[0] : ~com_w[0];
          else
            wave_nxt = wave_r;
        end
      endcase
    end
  end

  assign flags_nxt[`TMR_FLAG_OVF] = flag_upd(timer_irq_flags_r[`TMR_FLAG_OVF], ovf_evt_w,
    (wr_flags_w && wdat_w[`TMR_FLAG_OVF]) || irq_svc_i[`TMR_FLAG_OVF]);
  assign flags_nxt[`TMR_FLAG_CMP] = flag_upd(timer_irq_flags_r[`TMR_FLAG_CMP], cmp_evt_w,
    (wr_flags_w && wdat_w[`TMR_FLAG_CMP]) || irq_svc_i[`TMR_FLAG_CMP]);

  // Bus slave and registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o             <= 1'b0;
      wb_dat_o             <= 32'h0000_0000;
      ctrl_r               <= `TMR_RST_CTRL;
      timer_irq_masks_r    <= `TMR_RST_MASKS;
      timer_irq_flags_r    <= `TMR_RST_FLAGS;
      async_clock_select_r <= 1'b0;
      compare_value_r      <= `TMR_RST_COMPARE;
      irq_o                <= 1'b0;
    end
    else
    begin
      wb_ack_o <= acc_w;
      if (acc_w)
        wb_dat_o <= rdat_w;
      if (wr_ctrl_w)
        ctrl_r <= {1'b0, wdat_w[6:0]};
      if (wr_masks_w)
        timer_irq_masks_r <= wdat_w[1:0];
      if (wr_async_w)
        async_clock_select_r <= wdat_w[`TMR_ASYNC_SEL];
      if (wr_cmp_w)
        compare_value_r <= wdat_w;
      timer_irq_flags_r <= flags_nxt;
      irq_o <= |(flags_nxt & timer_irq_masks_r);
    end
  end

  // Counter, compare buffer, match pipeline
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_value_r    <= `TMR_RST_COUNT;
      dir_r            <= tmr_pkg::TMR_DIR_UP;
      compare_active_r <= `TMR_RST_COMPARE;
      match_pend_r     <= 1'b0;
      block_r          <= 1'b0;
    end
    else
    begin
      if (wr_count_w)
        count_value_r <= wdat_w;
      else if (timer_tick_w)
        count_value_r <= count_nxt;
      if (timer_tick_w)
        dir_r <= dir_nxt;
      // Buffer loads directly outside PWM, else at top
      if (!pwm_w)
        compare_active_r <= compare_value_r;
      else if (timer_tick_w && at_top_w)
        compare_active_r <= compare_value_r;
      if (timer_tick_w)
        match_pend_r <= match_w && !block_r;
      // Count write hides the match of the next tick
      if (wr_count_w)
        block_r <= 1'b1;
      else if (timer_tick_w)
        block_r <= 1'b0;
    end
  end

  // Pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      xin_s1_r           <= 1'b0;
      xin_s2_r           <= 1'b0;
      xin_s3_r           <= 1'b0;
      wave_r             <= 1'b0;
      compare_output_pin <= 1'b0;
      crystal_pin_out    <= 1'b0;
    end
    else
    begin
      xin_s1_r           <= crystal_pin_in;
      xin_s2_r           <= xin_s1_r;
      xin_s3_r           <= xin_s2_r;
      wave_r             <= wave_nxt;
      compare_output_pin <= (com_w != tmr_pkg::TMR_COM_OFF) ? wave_nxt : 1'b0;
      crystal_pin_out    <= async_clock_select_r & ~xin_s2_r;
    end
  end

endmodule : tmr_core

/* File: tmr_map.svh */
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// Register byte offsets
`define TMR_OFS_CTRL      8'h00
`define TMR_OFS_COUNT     8'h04
`define TMR_OFS_COMPARE   8'h08
`define TMR_OFS_FLAGS     8'h0C
`define TMR_OFS_MASKS     8'h10
`define TMR_OFS_ASYNC     8'h14

// Control fields
`define TMR_CTRL_CS_LSB   0
`define TMR_CTRL_WM_LSB   3
`define TMR_CTRL_COM_LSB  5
`define TMR_CTRL_FORCE    7

// Flag and mask bit positions
`define TMR_FLAG_OVF      0
`define TMR_FLAG_CMP      1

// Async status field
`define TMR_ASYNC_SEL     3

// Count range
`define TMR_BOTTOM        8'h00
`define TMR_MAX           8'hFF

// Reset values
`define TMR_RST_CTRL      8'h00
`define TMR_RST_COUNT     8'h00
`define TMR_RST_COMPARE   8'h00
`define TMR_RST_FLAGS     2'h0
`define TMR_RST_MASKS     2'h0

// Prescaler division masks
`define TMR_DIV8_MASK     10'h007
`define TMR_DIV32_MASK    10'h01F
`define TMR_DIV64_MASK    10'h03F
`define TMR_DIV128_MASK   10'h07F
`define TMR_DIV256_MASK   10'h0FF
`define TMR_DIV1024_MASK  10'h3FF

`endif

/* File: tmr_pkg.sv */
package tmr_pkg;

  typedef enum logic [1:0]
  {
    TMR_WAVE_NORMAL = 2'b00,
    TMR_WAVE_PHASE  = 2'b01,
    TMR_WAVE_CTC    = 2'b10,
    TMR_WAVE_FAST   = 2'b11
  } tmr_wave_t;

  typedef enum logic [1:0]
  {
    TMR_COM_OFF    = 2'b00,
    TMR_COM_TOGGLE = 2'b01,
    TMR_COM_CLEAR  = 2'b10,
    TMR_COM_SET    = 2'b11
  } tmr_com_t;

  typedef enum logic
  {
    TMR_DIR_UP   = 1'b0,
    TMR_DIR_DOWN = 1'b1
  } tmr_dir_t;

endpackage : tmr_pkg

/* File: tmr_prescale.sv */
`timescale 1ns/1ns
`include "tmr_map.svh"

module tmr_prescale #(
  parameter int PW = 10
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          src_tick_i,
  input  wire logic [2:0]    sel_i,
  output logic               tick_o
);

  logic [PW-1:0] pre_r;
  logic [PW-1:0] mask_w;
  logic          hit_w;

  function automatic logic [PW-1:0] div_mask(input logic [2:0] sel);
    logic [PW-1:0] m;
    m = '0;
    case (sel)
      3'h2:    m = PW'(`TMR_DIV8_MASK);
      3'h3:    m = PW'(`TMR_DIV32_MASK);
      3'h4:    m = PW'(`TMR_DIV64_MASK);
      3'h5:    m = PW'(`TMR_DIV128_MASK);
      3'h6:    m = PW'(`TMR_DIV256_MASK);
      3'h7:    m = PW'(`TMR_DIV1024_MASK);
      default: m = '0;
    endcase
    return m;
  endfunction : div_mask

  assign mask_w = div_mask(sel_i);
  // Select zero gives no tick at all
  assign hit_w  = src_tick_i && (sel_i != 3'h0) && ((pre_r & mask_w) == mask_w);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_r  <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      if (src_tick_i)
        pre_r <= pre_r + PW'(1);
      tick_o <= hit_w;
    end
  end

endmodule : tmr_prescale

/* File: tmr_properties.sv */
`timescale 1ns/1ns
module tmr_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  irq_svc_i,
  input wire logic        crystal_pin_in,
  input wire logic        crystal_pin_out,
  input wire logic        compare_output_pin,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_caused: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_reset_bus_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && wb_dat_o == 32'h0)
    else $error("bus outputs active after reset");
  a_reset_pins_quiet: assert property ($fell(rst_i) |-> !irq_o && !compare_output_pin)
    else $error("pins active after reset");
  a_irq_drop_cause: assert property ($fell(irq_o) |->
    $past(rst_i || irq_svc_i != 2'h0 || (wb_cyc_i && wb_stb_i && wb_we_i)))
    else $error("interrupt fell without clear");
  a_xtal_feedback: assert property (crystal_pin_out |-> !$past(crystal_pin_in, 3))
    else $error("oscillator feedback not inverted");
endmodule : tmr_checker

bind tmr_core tmr_checker u_tmr_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_svc_i(irq_svc_i),
  .crystal_pin_in(crystal_pin_in), .crystal_pin_out(crystal_pin_out),
  .compare_output_pin(compare_output_pin), .irq_o(irq_o));

/* File: tmr_xtal_model.sv */
`timescale 1ns/1ns
module tmr_xtal_model #(
  parameter int HALF_NS = 36
) (
  input  wire logic run_i,
  output logic      osc_o
);
  // Still while stopped so no stray edges reach the counter
  // Even half period keeps crystal edges off the rising clock edges
  initial osc_o = 1'b0;
  always
  begin
    #HALF_NS;
    osc_o = run_i ? ~osc_o : 1'b0;
  end
endmodule : tmr_xtal_model
